/* File: bench/adcprp_chk.sv */
`timescale 1ns/1ns
`default_nettype none
module adcprp_chk import adcprp_pkg::*; #(parameter int unsigned CONV_LEN = CONV_CYCLES,
  parameter int unsigned TRIM_LEN = TRIM_CONVERSIONS) (
  input wire logic         clk,
  input wire logic         sys_rst,
  input wire adcprp_host_t host_in,
  input wire logic [15:0]  sample_in,
  input wire logic         busy,
  input wire logic         result_valid,
  input wire adcprp_bus_t  result_out_bus);
  logic [15:0] smp_reg, res_reg;
  logic [7:0]  done_reg;
  wire off = host_in.chip_select_n | host_in.read_n;
  wire rd = !off && !busy;
  // Reads as busy falls race the result update, so they go unjudged
  always_ff @(posedge clk) if ($rose(busy)) smp_reg <= $past(sample_in);
  always_ff @(posedge clk) if ($fell(busy)) res_reg <= smp_reg;
  // Completed conversions so far, saturating
  always_ff @(posedge clk)
    if (sys_rst) done_reg <= 8'h00;
    else if ($fell(busy) && done_reg != 8'hff) done_reg <= done_reg + 8'h01;
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  busy_rise_a: assert property (!host_in.chip_select_n && !busy &&
    $fell(host_in.conversion_start_n) |=> busy) else $error("no busy");
  busy_len_a: assert property ($rose(busy) |-> ##CONV_LEN $fell(busy)) else $error("length");
  busy_idle_a: assert property (!busy && host_in.chip_select_n |=> !busy) else $error("stray busy");
  word_read_a: assert property (rd && !$fell(busy) && !host_in.byte_select |=>
    result_out_bus == {res_reg, 16'hffff}) else $error("word");
  fold_read_a: assert property (rd && !$fell(busy) && host_in.byte_select |=>
    result_out_bus == {res_reg[7:0], 24'hffffff}) else $error("fold");
  pins_off_a: assert property (off |=> result_out_bus == 32'h0) else $error("driven");
  valid_rise_a: assert property ($rose(result_valid) |-> $fell(busy)) else $error("valid");
  valid_keep_a: assert property (result_valid |=> result_valid) else $error("lost");
  trim_mark_a: assert property ($fell(busy) |-> result_valid == (done_reg >= TRIM_LEN)) else $error("trim");
endmodule // adcprp_chk
bind adcprp_top adcprp_chk #(.CONV_LEN(CONV_LEN), .TRIM_LEN(TRIM_LEN)) adcprp_chk_i (.clk, .sys_rst, .host_in,
  .sample_in, .busy, .result_valid, .result_out_bus);
`default_nettype wire

/* File: bench/adcprp_host.sv */
`timescale 1ns/1ns
`default_nettype none
module adcprp_host import adcprp_pkg::*; (
  input  wire logic         clk,
  input  wire logic         busy,
  input  wire adcprp_bus_t  result_out_bus,
  output var  adcprp_host_t host_in = 4'he);
  // One-cycle start pulse; then wait for busy to drop
  task automatic conv(input logic [3:0] h);
    @(posedge clk) host_in <= h;
    @(posedge clk) host_in <= 4'he;
    do @(posedge clk); while (busy);
  endtask
  task automatic rd(input logic [3:0] h, output adcprp_bus_t q);
    @(posedge clk) host_in <= h;
    repeat (2) @(posedge clk);
    q = result_out_bus;
    host_in <= 4'he;
  endtask
endmodule // adcprp_host
`default_nettype wire

/* File: bench/adcprp_top_tb.sv */
`timescale 1ns/1ns
`default_nettype none
module adcprp_top_tb import adcprp_pkg::*;;
  logic         clk = 1'b0, sys_rst = 1'b1, busy, result_valid;
  logic [15:0]  sample_in = 16'h0f0f;
  adcprp_host_t host_in;
  adcprp_bus_t  bus, q;
  int           n_fail = 0, n_checks = 0;
  always #20 clk = ~clk;
  adcprp_top #(.CONV_LEN(2), .TRIM_LEN(1)) adcprp_top_i (.clk, .sys_rst, .host_in, .sample_in, .busy,
    .result_valid, .result_out_bus(bus));
  adcprp_host adcprp_host_i (.clk, .busy, .result_out_bus(bus), .host_in);
  task automatic chk(input string nm, input logic [33:0] got, input logic [33:0] exp);
    n_checks++;
    n_fail += int'(got !== exp);
    if (got !== exp) $display("[FAIL] %s exp %h got %h", nm, exp, got);
  endtask
  task automatic wrap_up(input int late = 0);
    n_fail += late;
    $display("checks %0d fails %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial #40000 wrap_up(1);
  initial begin
    repeat (10) @(posedge clk);
    sys_rst <= 1'b0;
    chk("reset", {busy, result_valid, bus}, 0);
    $display("reset test done");
    adcprp_host_i.conv(4'h4);
    chk("trim", result_valid, 0);
    sample_in <= 16'ha5c3;
    fork
      adcprp_host_i.conv(4'h4);
      begin
        repeat (2) @(posedge clk);
        sample_in <= 16'h5a3c;
      end
    join
    chk("valid", result_valid, 1);
    $display("trim test done");
    adcprp_host_i.rd(4'h2, q);
    chk("word", q, 32'ha5c3ffff);
    $display("word read test done");
    adcprp_host_i.rd(4'ha, q);
    chk("off", q, 0);
    $display("release test done");
    adcprp_host_i.conv(4'hc);
    adcprp_host_i.rd(4'h3, q);
    chk("fold", q, 32'hc3ffffff);
    $display("fold test done");
    wrap_up();
  end
endmodule // adcprp_top_tb
`default_nettype wire

/* File: hw/adcprp_pkg.sv */
package adcprp_pkg;

  // Timing at the 25 MHz system clock
  localparam int unsigned CLK_PERIOD_NS     = 40;
  localparam int unsigned CONV_TIME_NS      = 700;
  // Longest time rounds down, never below one cycle
  localparam int unsigned CONV_CYCLES_RAW   = CONV_TIME_NS / CLK_PERIOD_NS;
  localparam int unsigned CONV_CYCLES       = (CONV_CYCLES_RAW < 1) ? 1 : CONV_CYCLES_RAW;
  localparam int unsigned TRIM_CONVERSIONS  = 3;

  localparam int unsigned RESULT_WIDTH      = 16;
  localparam int unsigned BYTE_WIDTH        = 8;
  localparam logic [15:0] RESULT_RESET      = 16'h0000;
  localparam logic [7:0]  FOLD_FILL         = 8'hff;

  typedef enum logic [0:0] {
    ADCPRP_ST_IDLE = 1'b0,
    ADCPRP_ST_CONV = 1'b1
  } adcprp_state_t;

  // Host-side strobes; byte select is active high, the rest active low
  typedef struct packed {
    logic chip_select_n;
    logic read_n;
    logic conversion_start_n;
    logic byte_select;
  } adcprp_host_t;

  // Data pins as a value and an output enable per bit
  typedef struct packed {
    logic [15:0] data;
    logic [15:0] oe;
  } adcprp_bus_t;

endpackage : adcprp_pkg

/* File: hw/adcprp_top.sv */
`timescale 1ns/1ns
`default_nettype none

module adcprp_top
  import adcprp_pkg::*;
#(
  parameter int unsigned CONV_LEN  = CONV_CYCLES,
  parameter int unsigned TRIM_LEN  = TRIM_CONVERSIONS
) (
  // System
  input  wire logic                    clk,
  input  wire logic                    sys_rst,
  // Host strobes
  input  wire adcprp_host_t            host_in,
  // Sampled analog result from the SAR core
  input  wire logic [RESULT_WIDTH-1:0] sample_in,
  // Status
  output var  logic                    busy,
  output var  logic                    result_valid,
  // Parallel data pins
  output var  adcprp_bus_t             result_out_bus
);

  localparam int unsigned CW = $clog2(CONV_LEN + 1);
  localparam int unsigned TW = $clog2(TRIM_LEN + 1);

  // Sequencer
  adcprp_state_t           state_reg;
  logic [CW-1:0]           count_reg;
  logic                    start_prev_reg;
  // Converted data
  logic [RESULT_WIDTH-1:0] hold_reg;
  logic [RESULT_WIDTH-1:0] result_reg;
  // Trim bookkeeping
  logic [TW-1:0]           trim_reg;
  logic                    trim_spent;
  // Decoded strobes and events
  logic                    start_fall;
  logic                    conv_idle;
  logic                    conv_done;
  logic                    output_enable;
  // Pin drivers
  logic [RESULT_WIDTH-1:0] pin_next;
  logic [RESULT_WIDTH-1:0] pin_data_reg;
  logic [RESULT_WIDTH-1:0] pin_oe_reg;

  // Start is an edge taken only while selected; the read enable is a level
  always_comb begin
    conv_idle     = (state_reg == ADCPRP_ST_IDLE);
    start_fall    = start_prev_reg && !host_in.conversion_start_n
                    && !host_in.chip_select_n;
    conv_done     = (state_reg == ADCPRP_ST_CONV)
                    && (count_reg == CW'(CONV_LEN - 1));
    output_enable = !host_in.chip_select_n && !host_in.read_n;
    trim_spent    = (trim_reg == TW'(TRIM_LEN));
  end

  // Resets to the idle level, so a start pin resting high gives no edge after reset
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      start_prev_reg <= 1'b1;
    end else begin
      start_prev_reg <= host_in.conversion_start_n;
    end
  end

  // Conversion sequencer on the system clock; no host clock used
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_reg <= ADCPRP_ST_IDLE;
    end else begin
      case (state_reg)
        ADCPRP_ST_IDLE: begin
          if (start_fall) begin
            state_reg <= ADCPRP_ST_CONV;
          end
        end
        ADCPRP_ST_CONV: begin
          if (conv_done) begin
            state_reg <= ADCPRP_ST_IDLE;
          end
        end
        default: begin
          state_reg <= ADCPRP_ST_IDLE;
        end
      endcase
    end
  end

  // Length counter starts clean for every conversion
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      count_reg <= '0;
    end else if (conv_idle || conv_done) begin
      count_reg <= '0;
    end else begin
      count_reg <= count_reg + CW'(1);
    end
  end

  // Busy rises the cycle after start and falls with the result update
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      busy <= 1'b0;
    end else if (start_fall && conv_idle) begin
      busy <= 1'b1;
    end else if (conv_done) begin
      busy <= 1'b0;
    end
  end

  // Input frozen at start; later input changes cannot disturb this conversion
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      hold_reg <= RESULT_RESET;
    end else if (start_fall && conv_idle) begin
      hold_reg <= sample_in;
    end
  end

  // Result changes only as busy falls, so a read never sees a half-made word
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      result_reg <= RESULT_RESET;
    end else if (conv_done) begin
      result_reg <= hold_reg;
    end
  end

  // Counts the trim conversions after reset, then rests
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      trim_reg <= '0;
    end else if (conv_done && !trim_spent) begin
      trim_reg <= trim_reg + TW'(1);
    end
  end

  // Set by the first conversion after the trim loads; a trim result is never flagged
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      result_valid <= 1'b0;
    end else if (conv_done && trim_spent) begin
      result_valid <= 1'b1;
    end
  end

  // One cell per data pin; the upper half takes the low byte when folded
  for (genvar i = 0; i < RESULT_WIDTH; i++) begin : g_pin
    if (i >= BYTE_WIDTH) begin : g_upper
      assign pin_next[i] = host_in.byte_select ? result_reg[i-BYTE_WIDTH] : result_reg[i];
    end else begin : g_lower
      assign pin_next[i] = host_in.byte_select ? FOLD_FILL[i] : result_reg[i];
    end
  end

  // Pin data lags the strobes by one cycle; released pins show zero
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pin_data_reg <= '0;
    end else if (output_enable) begin
      pin_data_reg <= pin_next;
    end else begin
      pin_data_reg <= '0;
    end
  end

  // All pins are enabled together, never a partial word
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pin_oe_reg <= '0;
    end else if (output_enable) begin
      pin_oe_reg <= '1;
    end else begin
      pin_oe_reg <= '0;
    end
  end

  assign result_out_bus = '{data: pin_data_reg, oe: pin_oe_reg};

endmodule : adcprp_top

`default_nettype wire
